// ### rtl/icpm_params.svh
`ifndef ICPM_PARAMS_SVH
`define ICPM_PARAMS_SVH

// register indices; byte address is four times the index
`define ICPM_IND_IDX 12'h452
`define ICPM_CLKO_IDX 12'h453
`define ICPM_STAT_IDX 12'h454

// reset values and writable bits
`define ICPM_IND_RST 16'h0000
`define ICPM_CLKO_RST 16'h0001
`define ICPM_IND_WMASK 16'hffff
`define ICPM_CLKO_WMASK 16'h81ff

// field positions
`define ICPM_LED1_SEL_LSB 8
`define ICPM_LED1_CFG_LSB 8
`define ICPM_LED0_CFG_LSB 0
`define ICPM_TXER_BIT 15
`define ICPM_CLKO_DIV_BIT 8

// pin select codes
`define ICPM_SEL_DEFAULT 3'h0
`define ICPM_SEL_CLOCK 3'h1

// last wait count: four edges pass after reset release before the strap is trusted
`define ICPM_STRAP_WAIT 2'h3

`endif

// ### rtl/icpm_pkg.sv
package icpm_pkg;

  // per-pin output path setup
  typedef struct packed {
    logic div2;
    logic [3:0] src;
    logic inv;
    logic [2:0] sel;
  } icpm_pin_cfg_t;

  // status functions shared by all three pins
  typedef struct packed {
    logic irq;
    logic esd;
    logic ts_rx;
    logic ts_tx;
    logic under_voltage;
    logic wake_event;
  } icpm_status_t;

  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN = 3'b100
  } icpm_strap_st_t;

endpackage

// ### rtl/icpm_top.sv
`timescale 1ns/1ps
`include "icpm_params.svh"
module icpm_top
  import icpm_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // status sources, same clock domain
  input wire logic link,
  input wire logic link_act,
  input wire icpm_status_t status,
  // clock mux sources, foreign domains
  input wire logic [15:0] clk_src,
  // straps
  input wire logic receive_data3_strap,
  // pins
  output logic led0_o,
  output logic led1_o,
  output logic led1_oe,
  input wire logic led1_i,
  output logic clk_out_o,
  // mac side
  output logic transmit_error
);

  logic [15:0] ind_q;
  logic [15:0] clko_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [15:0] cs1_q, cs2_q, cs3_q, cclean_q;
  logic [2:0] strap_s_q;
  logic strap_clean_q;
  logic [2:0] txer_s_q;
  logic txer_clean_q;
  icpm_strap_st_t st_q;
  logic [1:0] wait_q;
  logic [2:0] prev_q;
  logic [2:0] div_q;
  logic led0_q, led1_q, led1_oe_q, clk_out_q, txer_q;
  icpm_pin_cfg_t cfg [3];
  logic [2:0] sel_clk;
  logic [2:0] pin_val;
  logic setup, wr_en, hit_ind, hit_clko, hit_stat;

  function automatic logic addr_hit(input logic [31:0] a,
                                    input logic [11:0] idx);
    addr_hit = (a == {18'h0, idx, 2'h0});
  endfunction

  // status functions for codes 010..111; code 000 is the pin default
  function automatic logic pin_status(input logic [2:0] sel,
                                      input logic dflt,
                                      input icpm_status_t s);
    case (sel)
      3'h0: pin_status = dflt;
      3'h2: pin_status = s.wake_event;
      3'h3: pin_status = s.under_voltage;
      3'h4: pin_status = s.ts_tx;
      3'h5: pin_status = s.ts_rx;
      3'h6: pin_status = s.esd;
      3'h7: pin_status = s.irq;
      default: pin_status = 1'b0;
    endcase
  endfunction

  function automatic icpm_pin_cfg_t ind_cfg(input logic [7:0] f);
    ind_cfg.div2 = f[7];
    ind_cfg.src = {1'b0, f[6:4]};
    ind_cfg.inv = f[3];
    ind_cfg.sel = f[2:0];
  endfunction

  // apb decode
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready_q;
  assign hit_ind = addr_hit(paddr, `ICPM_IND_IDX);
  assign hit_clko = addr_hit(paddr, `ICPM_CLKO_IDX);
  assign hit_stat = addr_hit(paddr, `ICPM_STAT_IDX);

  // no wait state: answer is prepared in setup and shown in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~(hit_ind | hit_clko | hit_stat);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (setup && !pwrite) begin
      if (hit_ind) begin
        prdata_q <= {16'h0, ind_q};
      end else if (hit_clko) begin
        prdata_q <= {16'h0, clko_q};
      end else if (hit_stat) begin
        prdata_q <= {27'h0, clk_out_q, led1_q, led0_q, txer_q,
                     strap_clean_q};
      end else begin
        prdata_q <= 32'h0;
      end
    end else if (!psel) begin
      prdata_q <= 32'h0;
    end
  end

  // strap sampling: reset must load a constant, so the strap value
  // is folded in by a clocked step once the synchroniser has settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s_q <= 3'h0;
      strap_clean_q <= 1'b0;
    end else begin
      strap_s_q <= {strap_s_q[1:0], receive_data3_strap};
      if (strap_s_q[1] == strap_s_q[2]) begin
        strap_clean_q <= strap_s_q[2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_WAIT;
      wait_q <= 2'h0;
    end else begin
      case (st_q)
        ST_WAIT: begin
          wait_q <= wait_q + 2'h1;
          if (wait_q == `ICPM_STRAP_WAIT) begin
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD: st_q <= ST_RUN;
        ST_RUN: st_q <= ST_RUN;
        default: st_q <= ST_WAIT;
      endcase
    end
  end

  // a software write in the load cycle takes precedence over the strap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_q <= `ICPM_IND_RST;
    end else if (wr_en && hit_ind) begin
      ind_q <= pwdata[15:0] & `ICPM_IND_WMASK;
    end else if (st_q == ST_LOAD && strap_clean_q) begin
      ind_q[`ICPM_LED1_SEL_LSB +: 3] <= `ICPM_SEL_CLOCK;
    end
  end

  // reserved bits 14..9 are never written and read back zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clko_q <= `ICPM_CLKO_RST;
    end else if (wr_en && hit_clko) begin
      clko_q <= pwdata[15:0] & `ICPM_CLKO_WMASK;
    end
  end

  // pin 0 first indicator, 1 second indicator, 2 clock out
  always_comb begin
    cfg[0] = ind_cfg(ind_q[`ICPM_LED0_CFG_LSB +: 8]);
    cfg[1] = ind_cfg(ind_q[`ICPM_LED1_CFG_LSB +: 8]);
    cfg[2].div2 = clko_q[`ICPM_CLKO_DIV_BIT];
    cfg[2].src = clko_q[7:4];
    cfg[2].inv = clko_q[3];
    cfg[2].sel = clko_q[2:0];
  end

  // clock sources are sampled, so only sources well below half of
  // pclk come through faithfully; faster ones alias
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs1_q <= 16'h0;
      cs2_q <= 16'h0;
      cs3_q <= 16'h0;
      cclean_q <= 16'h0;
    end else begin
      cs1_q <= clk_src;
      cs2_q <= cs1_q;
      cs3_q <= cs2_q;
      cclean_q <= (cclean_q & (cs2_q ^ cs3_q))
                | (cs3_q & ~(cs2_q ^ cs3_q));
    end
  end

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      sel_clk[p] = cclean_q[cfg[p].src];
    end
  end

  // divide by two toggles on each rising edge of the chosen source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 3'h0;
      div_q <= 3'h0;
    end else begin
      prev_q <= sel_clk;
      div_q <= div_q ^ (sel_clk & ~prev_q);
    end
  end

  // divide first, then invert, and only when the clock is chosen
  always_comb begin
    logic base;
    base = 1'b0;
    for (int p = 0; p < 3; p++) begin
      base = cfg[p].div2 ? div_q[p] : sel_clk[p];
      if (p == 0) begin
        pin_val[p] = pin_status(cfg[p].sel, link, status);
      end else if (p == 1) begin
        pin_val[p] = pin_status(cfg[p].sel, link_act, status);
      end else begin
        pin_val[p] = pin_status(cfg[p].sel, pin_val[1], status);
      end
      if (cfg[p].sel == `ICPM_SEL_CLOCK) begin
        pin_val[p] = base ^ cfg[p].inv;
      end
    end
  end

  // transmit error arrives on the second indicator pin when routed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txer_s_q <= 3'h0;
      txer_clean_q <= 1'b0;
    end else begin
      txer_s_q <= {txer_s_q[1:0], led1_i};
      if (txer_s_q[1] == txer_s_q[2]) begin
        txer_clean_q <= txer_s_q[2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led0_q <= 1'b0;
      led1_q <= 1'b0;
      led1_oe_q <= 1'b0;
      clk_out_q <= 1'b0;
      txer_q <= 1'b0;
    end else begin
      led0_q <= pin_val[0];
      led1_q <= pin_val[1];
      led1_oe_q <= ~clko_q[`ICPM_TXER_BIT];
      clk_out_q <= pin_val[2];
      txer_q <= clko_q[`ICPM_TXER_BIT] & txer_clean_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign led0_o = led0_q;
  assign led1_o = led1_q;
  assign led1_oe = led1_oe_q;
  assign clk_out_o = clk_out_q;
  assign transmit_error = txer_q;

endmodule

// ### testbench/icpm_monitor.sv
`timescale 1ns/1ps
module icpm_monitor
  import icpm_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // functions and pins
  input wire logic link,
  input wire icpm_status_t status,
  input wire logic led0_o,
  input wire logic led1_oe,
  input wire logic clk_out_o,
  input wire logic transmit_error
);
  // shadow of software writes; strap-loaded bits are never compared
  logic [15:0] ind_q;
  logic [15:0] clko_q;
  logic [1:0] age_q;
  logic wr;
  assign wr = psel & penable & pready & pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_q <= 16'h0000;
      clko_q <= 16'h0001;
      age_q <= 2'h0;
    end else begin
      if (age_q != 2'h3)
        age_q <= age_q + 2'h1;
      if (wr && paddr == 32'h1148)
        ind_q <= pwdata[15:0];
      if (wr && paddr == 32'h114c)
        clko_q <= pwdata[15:0] & 16'h81ff;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd(a);
    psel && !penable && !pwrite && paddr == a ##1 pready;
  endsequence
  chk_led0_link: assert property (
    age_q == 2'h3 && ind_q[2:0] == 3'h0 && $past(ind_q[2:0]) == 3'h0
    |-> led0_o == $past(link)) else $error("first pin lost link");
  chk_led0_stat: assert property (
    age_q == 2'h3 && ind_q[2:1] != 2'h0 && $stable(ind_q[2:0])
    |-> led0_o == $past(status[ind_q[2:0] - 3'h2]))
    else $error("first pin status wrong");
  chk_clko_stat: assert property (
    age_q == 2'h3 && clko_q[2:1] != 2'h0 && $stable(clko_q[2:0])
    |-> clk_out_o == $past(status[clko_q[2:0] - 3'h2]))
    else $error("clock pin status wrong");
  chk_oe_off: assert property (
    clko_q[15] && $past(clko_q[15]) |-> !led1_oe)
    else $error("second pin driven while input");
  chk_oe_on: assert property (
    age_q == 2'h3 && !clko_q[15] && !$past(clko_q[15]) |-> led1_oe)
    else $error("second pin not driven");
  chk_txer_off: assert property (
    !clko_q[15] && !$past(clko_q[15]) |-> !transmit_error)
    else $error("error line active while routing off");
  chk_clko_read: assert property (
    s_rd(32'h114c) |-> prdata == {16'h0000, clko_q})
    else $error("clock-out word read wrong");
  chk_ind_read: assert property (
    s_rd(32'h1148) |-> prdata[7:0] == ind_q[7:0] && prdata[31:16] == 16'h0)
    else $error("indicator word read wrong");
endmodule
bind icpm_top icpm_monitor i_mon (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .link(link),
  .status(status),
  .led0_o(led0_o),
  .led1_oe(led1_oe),
  .clk_out_o(clk_out_o),
  .transmit_error(transmit_error)
);

// ### testbench/indicator_clock_pin_mux_bench.sv
`timescale 1ns/1ps
module indicator_clock_pin_mux_bench import icpm_pkg::*;;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, link = 1'h0, link_act = 1'h0, led1_i = 1'h0;
  logic receive_data3_strap = 1'h1;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, led0_o, led1_o, led1_oe;
  logic clk_out_o, transmit_error;
  icpm_status_t status = '0;
  logic [15:0] clk_src = 16'h0000;
  wire [2:0] pv = {clk_out_o, led1_o, led0_o};
  int num_errors = 0, n_compared = 0;
  always #10 pclk = ~pclk;
  icpm_top i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .link(link),
    .link_act(link_act),
    .status(status),
    .clk_src(clk_src),
    .receive_data3_strap(receive_data3_strap),
    .led0_o(led0_o),
    .led1_o(led1_o),
    .led1_oe(led1_oe),
    .led1_i(led1_i),
    .clk_out_o(clk_out_o),
    .transmit_error(transmit_error)
  );
  task automatic chk(input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'h1 && i < 20);
    if (pready !== 1'h1) begin
      num_errors++;
      $display("ERROR %0t: no ready from register bus", $time);
      finish_test;
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
    end
  endtask
  // slow source so the pclk sampler sees every edge; counts pin changes
  task automatic cnt(input int s, p, n);
    int k;
    logic v;
    k = 0;
    tick(8);
    v = pv[p];
    for (int i = 0; i < 17; i++) begin
      if (i < 16)
        clk_src[s] <= ~clk_src[s];
      repeat (8) begin
        @(posedge pclk);
        if (pv[p] !== v)
          k++;
        v = pv[p];
      end
    end
    chk(k, n);
  endtask
  task automatic t_reset;
    apb(1'h0, 32'h1148, 32'h0);
    chk(rd, 32'h0100);
    apb(1'h1, 32'h114c, 32'hffff);
    apb(1'h0, 32'h114c, 32'h0);
    chk(rd, 32'h81ff);
    chk(er, 1'h0);
    apb(1'h0, 32'h2000, 32'h0);
    chk(er, 1'h1);
    chk(rd, 32'h0);
    presetn <= 1'h0;
    receive_data3_strap <= 1'h0;
    tick(2);
    presetn <= 1'h1;
    tick(8);
    apb(1'h0, 32'h1148, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 32'h114c, 32'h0);
    chk(rd, 32'h1);
    $display("reset test end");
  endtask
  task automatic t_default;
    apb(1'h1, 32'h1148, 32'h0);
    apb(1'h1, 32'h114c, 32'h0);
    link <= 1'h1;
    tick(3);
    chk(pv, 3'h1);
    link <= 1'h0;
    link_act <= 1'h1;
    tick(3);
    chk(pv, 3'h6);
    $display("default test end");
  endtask
  task automatic t_status;
    for (int c = 2; c < 8; c++) begin
      apb(1'h1, 32'h1148, 32'h8888 | (c << 8) | c);
      apb(1'h1, 32'h114c, 32'h0108 | c);
      status <= icpm_status_t'(6'h1 << (c - 2));
      tick(3);
      chk(pv, 3'h7);
      status <= '0;
      tick(3);
      chk(pv, 3'h0);
    end
    $display("status test end");
  endtask
  task automatic t_clock;
    apb(1'h1, 32'h1148, 32'he1b9);
    apb(1'h1, 32'h114c, 32'h0191);
    cnt(3, 0, 8);
    cnt(6, 1, 8);
    cnt(9, 2, 8);
    apb(1'h1, 32'h1148, 32'h6939);
    cnt(6, 1, 16);
    chk(pv[1:0], 2'h3);
    $display("clock test end");
  endtask
  task automatic t_txer;
    apb(1'h1, 32'h114c, 32'h8001);
    tick(3);
    chk(led1_oe, 1'h0);
    led1_i <= 1'h1;
    tick(8);
    chk(transmit_error, 1'h1);
    // status word: clock pin low, both indicators high, error seen
    apb(1'h0, 32'h1150, 32'h0);
    chk(rd, 32'he);
    led1_i <= 1'h0;
    tick(8);
    chk(transmit_error, 1'h0);
    led1_i <= 1'h1;
    apb(1'h1, 32'h114c, 32'h0001);
    tick(3);
    chk({led1_oe, transmit_error}, 2'h2);
    $display("routing test end");
  endtask
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    tick(3);
    presetn <= 1'h1;
    tick(8);
    t_reset;
    t_default;
    t_status;
    t_clock;
    t_txer;
    finish_test;
  end
endmodule
